/* File: logic/cso_alu_flags.v */
// Purpose: Result and flag computation for add, subtract, rotate and logic results
// Assumes: Purely combinational; caller registers everything
// Notes:   Subtract is formed as a + ~b + carry, or a + ~b + 1 with carry_in_en low, so carry reads as not-borrow
`timescale 1ns/100ps
`default_nettype none
`include "cso_defines.vh"

module cso_alu_flags (
   input  wire [2:0] op,
   input  wire [7:0] opa,
   input  wire [7:0] opb,
   input  wire       carry_now,
   input  wire       carry_in_en,
   output reg  [7:0] result,
   output reg        zero_out,
   output reg        nibble_out,
   output reg        carry_out,
   output reg        upd_zero,
   output reg        upd_nibble,
   output reg        upd_carry
);

   reg  [7:0] operand_b;
   reg        cin;
   reg  [4:0] low_sum;
   reg  [8:0] full_sum;
   reg        is_sub;

   always @* begin
      is_sub     = (op == `CSO_OP_SUB);
      operand_b  = is_sub ? ~opb : opb;
      if (carry_in_en)
         cin = carry_now;
      else
         cin = is_sub;
      low_sum    = {1'b0, opa[3:0]} + {1'b0, operand_b[3:0]} + {4'h0, cin};
      full_sum   = {1'b0, opa} + {1'b0, operand_b} + {8'h00, cin};
      result     = opa;
      zero_out   = 1'b0;
      nibble_out = 1'b0;
      carry_out  = 1'b0;
      upd_zero   = 1'b0;
      upd_nibble = 1'b0;
      upd_carry  = 1'b0;
      case (op)
         `CSO_OP_ADD, `CSO_OP_SUB: begin
            result     = full_sum[7:0];
            nibble_out = low_sum[4];
            carry_out  = full_sum[8];
            upd_zero   = 1'b1;
            upd_nibble = 1'b1;
            upd_carry  = 1'b1;
         end
         `CSO_OP_ROR: begin
            result    = {carry_now, opa[7:1]};
            carry_out = opa[0];
            upd_carry = 1'b1;
         end
         `CSO_OP_ROL: begin
            result    = {opa[6:0], carry_now};
            carry_out = opa[7];
            upd_carry = 1'b1;
         end
         `CSO_OP_LOGIC: begin
            result   = opa;
            upd_zero = 1'b1;
         end
         default: begin
            result = opa;
         end
      endcase
      zero_out = (result == 8'h00);
   end

endmodule // cso_alu_flags

`default_nettype wire

/* File: logic/cso_defines.vh */
// Purpose: Shared constants for the status, program counter and option register bank
// Assumes: Included by bare name; definitions only
// Notes:   Offsets are file addresses seen by the instruction core
`ifndef CSO_DEFINES_VH
`define CSO_DEFINES_VH

// File addresses
`define CSO_ADDR_REG1          5'h01
`define CSO_ADDR_PC_LOW        5'h02
`define CSO_ADDR_STATUS        5'h03

// Status bit positions
`define CSO_ST_CARRY           0
`define CSO_ST_NIBBLE          1
`define CSO_ST_ZERO            2
`define CSO_ST_SLEEP           3
`define CSO_ST_WDOG            4
`define CSO_ST_PAGE_LO         5
`define CSO_ST_PAGE_HI         7

// Option bit positions
`define CSO_OPT_RATIO_LO       0
`define CSO_OPT_RATIO_HI       2
`define CSO_OPT_PS_ASSIGN      3
`define CSO_OPT_EDGE_SEL       4
`define CSO_OPT_CLK_SRC        5
`define CSO_OPT_IRQ_MASK       6
`define CSO_OPT_MAP_SEL        7

// Reset values
`define CSO_OPTION_RESET       8'hFF
`define CSO_STATUS_RESET       8'h18
`define CSO_PC_RESET           8'h00
`define CSO_CFG_RESET          12'hFFF

// Page geometry: 512 words per page
`define CSO_PAGE_WORDS         12'h200

// ALU operation codes
`define CSO_OP_NONE            3'h0
`define CSO_OP_ADD             3'h1
`define CSO_OP_SUB             3'h2
`define CSO_OP_ROR             3'h3
`define CSO_OP_ROL             3'h4
`define CSO_OP_LOGIC           3'h5

// Configuration word selection in programming mode
`define CSO_CFG_MAIN           2'h0
`define CSO_CFG_EXT            2'h1
`define CSO_CFG_DEVICE         2'h2

// Fuse bit positions inside the extended configuration word
`define CSO_FUSE_CARRY_IN      5
`define CSO_FUSE_EXT_OPT       6

`endif

/* File: logic/cso_regs.v */
// Purpose: Program counter low byte, status and option registers with configuration words
// Assumes: All inputs come from core logic on core_clk; no pin inputs
// Notes:   ALU flag updates land after a status write in the same cycle
`timescale 1ns/100ps
`default_nettype none
`include "cso_defines.vh"

module cso_regs #(
   parameter [11:0] DEVICE_ID = 12'h5A5   // Arbitrary identity value
) (
   input  wire        core_clk,
   input  wire        resetn,
   input  wire        ce,
   input  wire        power_on,
   input  wire [4:0]  file_addr,
   input  wire        file_wr_en,
   input  wire        file_rd_en,
   input  wire [7:0]  file_wr_data,
   output reg  [7:0]  file_rd_data,
   input  wire        pc_step,
   input  wire        option_wr_en,
   input  wire [7:0]  option_wr_data,
   input  wire        alu_valid,
   input  wire [2:0]  alu_op,
   input  wire [7:0]  alu_opa,
   input  wire [7:0]  alu_opb,
   output reg  [7:0]  alu_result,
   input  wire        watchdog_kick_instr,
   input  wire        sleep_instr,
   input  wire        watchdog_timeout,
   input  wire        prog_mode,
   input  wire        cfg_wr_en,
   input  wire [1:0]  cfg_sel,
   input  wire [11:0] cfg_wr_data,
   output reg  [11:0] cfg_rd_data,
   output reg  [7:0]  program_counter_low,
   output reg  [7:0]  alu_flags_and_page,
   output reg  [7:0]  counter_prescale_config,
   output reg  [2:0]  page_select,
   output reg  [11:0] page_base,
   output reg         watchdog_expired,
   output reg         sleep_entered_flag,
   output reg         reg1_map_sel,
   output reg         rollover_irq_mask,
   output reg         count_clk_src,
   output reg         count_edge_sel,
   output reg         prescaler_assign,
   output reg  [2:0]  prescale_ratio,
   output reg  [7:0]  counter_ratio_onehot,
   output reg  [7:0]  watchdog_ratio_onehot,
   output reg  [11:0] config_word,
   output reg  [11:0] extended_config_word
);

   wire [7:0] alu_res;
   wire       alu_zero;
   wire       alu_nibble;
   wire       alu_carry;
   wire       upd_zero;
   wire       upd_nibble;
   wire       upd_carry;
   wire       carry_input_fuse;
   wire       extended_opt_fuse;
   wire       wr_pc;
   wire       wr_status;
   wire       alu_go;

   reg  [7:0]  next_pc;
   reg  [7:0]  next_status;
   reg  [7:0]  next_option;
   reg  [7:0]  next_rd_data;
   reg  [11:0] next_cfg_rd;
   reg  [11:0] next_config;
   reg  [11:0] next_ext_config;
   wire [7:0]  ratio_onehot;

   assign carry_input_fuse  = extended_config_word[`CSO_FUSE_CARRY_IN];
   assign extended_opt_fuse = extended_config_word[`CSO_FUSE_EXT_OPT];
   assign wr_pc             = file_wr_en && (file_addr == `CSO_ADDR_PC_LOW);
   assign wr_status         = file_wr_en && (file_addr == `CSO_ADDR_STATUS);
   assign alu_go            = alu_valid && (alu_op != `CSO_OP_NONE);

   cso_alu_flags u_alu_flags (
      .op          (alu_op),
      .opa         (alu_opa),
      .opb         (alu_opb),
      .carry_now   (alu_flags_and_page[`CSO_ST_CARRY]),
      .carry_in_en (~carry_input_fuse),
      .result      (alu_res),
      .zero_out    (alu_zero),
      .nibble_out  (alu_nibble),
      .carry_out   (alu_carry),
      .upd_zero    (upd_zero),
      .upd_nibble  (upd_nibble),
      .upd_carry   (upd_carry)
   );

   // Program counter low byte
   always @* begin
      next_pc = program_counter_low;
      if (wr_pc)
         next_pc = file_wr_data;
      else if (pc_step)
         next_pc = program_counter_low + 8'h01;
   end

   // Status register
   always @* begin
      next_status = alu_flags_and_page;
      // sleep and watchdog bits ignore writes
      // writes load only the page, zero, nibble and carry bits
      if (wr_status) begin
         next_status[`CSO_ST_PAGE_HI:`CSO_ST_PAGE_LO] = file_wr_data[`CSO_ST_PAGE_HI:`CSO_ST_PAGE_LO];
         next_status[`CSO_ST_ZERO]                    = file_wr_data[`CSO_ST_ZERO];
         next_status[`CSO_ST_NIBBLE]                  = file_wr_data[`CSO_ST_NIBBLE];
         next_status[`CSO_ST_CARRY]                   = file_wr_data[`CSO_ST_CARRY];
      end
      if (alu_go) begin
         if (upd_zero)
            next_status[`CSO_ST_ZERO] = alu_zero;
         if (upd_nibble)
            next_status[`CSO_ST_NIBBLE] = alu_nibble;
         if (upd_carry)
            next_status[`CSO_ST_CARRY] = alu_carry;
      end
      if (watchdog_timeout)
         next_status[`CSO_ST_WDOG] = 1'b0;
      else if (watchdog_kick_instr || sleep_instr)
         next_status[`CSO_ST_WDOG] = 1'b1;
      if (sleep_instr)
         next_status[`CSO_ST_SLEEP] = 1'b0;
      else if (watchdog_kick_instr)
         next_status[`CSO_ST_SLEEP] = 1'b1;
      if (power_on) begin
         next_status[`CSO_ST_WDOG]  = 1'b1;
         next_status[`CSO_ST_SLEEP] = 1'b1;
      end
   end

   // Option register
   always @* begin
      next_option = counter_prescale_config;
      if (option_wr_en)
         next_option = option_wr_data;
      // bits 7,6 only active with fuse cleared
      if (extended_opt_fuse) begin
         next_option[`CSO_OPT_MAP_SEL]  = 1'b1;
         next_option[`CSO_OPT_IRQ_MASK] = 1'b1;
      end
   end

   // Register read port
   always @* begin
      case (file_addr)
         `CSO_ADDR_PC_LOW: begin
            next_rd_data = next_pc;
         end
         `CSO_ADDR_STATUS: begin
            next_rd_data = alu_flags_and_page;
         end
         default: begin
            next_rd_data = 8'h00;
         end
      endcase
      if (!file_rd_en)
         next_rd_data = file_rd_data;
      if (wr_pc)
         next_rd_data = file_rd_data;
   end

   // Configuration words
   always @* begin
      next_config     = config_word;
      next_ext_config = extended_config_word;
      next_cfg_rd     = 12'h000;
      if (prog_mode) begin
         if (cfg_wr_en && (cfg_sel == `CSO_CFG_MAIN))
            next_config = cfg_wr_data;
         if (cfg_wr_en && (cfg_sel == `CSO_CFG_EXT))
            next_ext_config = cfg_wr_data;
         case (cfg_sel)
            `CSO_CFG_MAIN: begin
               next_cfg_rd = config_word;
            end
            `CSO_CFG_EXT: begin
               next_cfg_rd = extended_config_word;
            end
            `CSO_CFG_DEVICE: begin
               next_cfg_rd = DEVICE_ID;
            end
            default: begin
               next_cfg_rd = 12'h000;
            end
         endcase
      end
   end

   // Ratio decode, one bit per prescaler code
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1) begin : g_ratio
         assign ratio_onehot[gi] = ({29'h0, counter_prescale_config[`CSO_OPT_RATIO_HI:`CSO_OPT_RATIO_LO]} == gi);
      end
   endgenerate

   // State registers
   always @(posedge core_clk) begin
      // Reset waits for the clock enable so a frozen bank stays frozen
      if (ce && !resetn) begin
         program_counter_low     <= `CSO_PC_RESET;
         alu_flags_and_page      <= `CSO_STATUS_RESET;
         counter_prescale_config <= `CSO_OPTION_RESET;
         file_rd_data            <= 8'h00;
         cfg_rd_data             <= 12'h000;
         alu_result              <= 8'h00;
      end else if (ce) begin
         program_counter_low     <= next_pc;
         alu_flags_and_page      <= next_status;
         counter_prescale_config <= next_option;
         file_rd_data            <= next_rd_data;
         cfg_rd_data             <= next_cfg_rd;
         if (alu_go)
            alu_result <= alu_res;
      end
   end

   // Configuration words survive core reset; only power-up outside programming mode restores them
   always @(posedge core_clk) begin
      if (ce) begin
         if (power_on && !prog_mode) begin
            config_word          <= `CSO_CFG_RESET;
            extended_config_word <= `CSO_CFG_RESET;
         end else begin
            config_word          <= next_config;
            extended_config_word <= next_ext_config;
         end
      end
   end

   // Decoded outputs, registered from next values so they track the registers; ratio one-hots decode current values, one cycle later
   always @(posedge core_clk) begin
      if (ce && !resetn) begin
         page_select           <= 3'h0;
         page_base             <= 12'h000;
         watchdog_expired      <= 1'b1;
         sleep_entered_flag    <= 1'b1;
         reg1_map_sel          <= 1'b1;
         rollover_irq_mask     <= 1'b1;
         count_clk_src         <= 1'b1;
         count_edge_sel        <= 1'b1;
         prescaler_assign      <= 1'b1;
         prescale_ratio        <= 3'h7;
         counter_ratio_onehot  <= 8'h00;
         watchdog_ratio_onehot <= 8'h00;
      end else if (ce) begin
         page_select        <= next_status[`CSO_ST_PAGE_HI:`CSO_ST_PAGE_LO];
         page_base          <= {1'b0, next_status[`CSO_ST_PAGE_HI:`CSO_ST_PAGE_LO], 8'h00} << 1;
         watchdog_expired   <= next_status[`CSO_ST_WDOG];
         sleep_entered_flag <= next_status[`CSO_ST_SLEEP];
         reg1_map_sel       <= next_option[`CSO_OPT_MAP_SEL];
         rollover_irq_mask  <= next_option[`CSO_OPT_IRQ_MASK];
         count_clk_src      <= next_option[`CSO_OPT_CLK_SRC];
         count_edge_sel     <= next_option[`CSO_OPT_EDGE_SEL];
         prescaler_assign   <= next_option[`CSO_OPT_PS_ASSIGN];
         prescale_ratio     <= next_option[`CSO_OPT_RATIO_HI:`CSO_OPT_RATIO_LO];
         if (counter_prescale_config[`CSO_OPT_PS_ASSIGN]) begin
            counter_ratio_onehot  <= 8'h00;
            watchdog_ratio_onehot <= ratio_onehot;
         end else begin
            counter_ratio_onehot  <= ratio_onehot;
            watchdog_ratio_onehot <= 8'h00;
         end
      end
   end

endmodule // cso_regs

`default_nettype wire

/* File: verif/cpu_status_option_regs_bench.sv */
// Purpose: Self-checking bench for the status, program counter and option register bank
// Assumes: Core model drives requests 1 ns after a rising edge
// Notes:   Operands come from a fixed-seed shift register
`timescale 1ns/100ps
`default_nettype none
`include "cso_defines.vh"
module cpu_status_option_regs_bench;
   localparam logic [11:0] ID = 12'h3C3; // Arbitrary identity value
   logic        core_clk = 1'b0;
   logic        resetn = 1'b0;
   logic        ce = 1'b1;
   logic [31:0] seed = 32'h7FAB932C;
   logic [2:0]  fl = 3'h0;
   logic [1:0]  st43 = 2'h3;
   logic        cf = 1'b1;
   logic [10:0] e;
   int          errors, cmp_count, cycles;
   wire logic power_on, file_wr_en, file_rd_en, pc_step, option_wr_en, alu_valid, prog_mode, cfg_wr_en;
   wire logic watchdog_kick_instr, sleep_instr, watchdog_timeout;
   wire logic watchdog_expired, sleep_entered_flag, reg1_map_sel, rollover_irq_mask;
   wire logic count_clk_src, count_edge_sel, prescaler_assign;
   wire logic [2:0] prescale_ratio;
   wire logic [7:0] counter_ratio_onehot, watchdog_ratio_onehot;
   wire logic [1:0] cfg_sel;
   wire logic [2:0] alu_op, page_select;
   wire logic [4:0] file_addr;
   wire logic [7:0] file_wr_data, option_wr_data, alu_opa, alu_opb, file_rd_data, alu_result;
   wire logic [7:0] program_counter_low, alu_flags_and_page, counter_prescale_config;
   wire logic [11:0] cfg_wr_data, cfg_rd_data, page_base, extended_config_word, config_word;

   cso_core_model core_u (.*);
   cso_regs #(.DEVICE_ID(ID)) dut_u (.*);

   always #50 core_clk = ~core_clk;

   always @(posedge core_clk) begin
      cycles++;
      if (cycles == 2000) begin
         errors++;
         complete_run();
      end
   end

   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Returns carry, nibble, zero and result; f holds carry, nibble, zero before
   function automatic logic [10:0] alu_exp(input logic [2:0] op, input logic [7:0] a, input logic [7:0] b,
                                           input logic [2:0] f, input logic fuse);
      logic [7:0] bb;
      logic       ci;
      logic [8:0] s;
      logic [4:0] n;
      bb = (op == `CSO_OP_SUB) ? ~b : b;
      ci = fuse ? (op == `CSO_OP_SUB) : f[2];
      s = a + bb + ci;
      n = a[3:0] + bb[3:0] + ci;
      if (op == `CSO_OP_ROR)
         return {a[0], f[1:0], f[2], a[7:1]};
      if (op == `CSO_OP_ROL)
         return {a[7], f[1:0], a[6:0], f[2]};
      if (op == `CSO_OP_LOGIC)
         return {f[2:1], a == 8'h00, a};
      return {s[8], n[4], s[7:0] == 8'h00, s[7:0]};
   endfunction

   task automatic check(input logic [23:0] got, input logic [23:0] exp, input string what);
      cmp_count++;
      if (got !== exp) begin
         errors++;
         $display("[ERR] %0t %s: got %h expected %h", $time, what, got, exp);
      end
   endtask

   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      core_u.file_addr = a;
      core_u.file_wr_data = d;
      core_u.file_wr_en = 1'b1;
      core_u.go();
   endtask

   task automatic cfg(input logic [1:0] sel, input logic [11:0] d);
      core_u.cfg_sel = sel;
      core_u.cfg_wr_data = d;
      core_u.cfg_wr_en = 1'b1;
      core_u.go();
   endtask

   task automatic alu_run(input int n);
      logic [2:0] op;
      repeat (n) begin
         seed = lfsr(seed);
         op = seed[2:0] % 3'd5 + 3'd1;
         {core_u.alu_op, core_u.alu_opa, core_u.alu_opb, core_u.alu_valid} = {op, seed[15:0], 1'b1};
         e = alu_exp(op, seed[15:8], seed[7:0], fl, cf);
         core_u.go();
         check({alu_flags_and_page[0], alu_flags_and_page[1], alu_flags_and_page[2], alu_result},
               e, "alu");
         fl = e[10:8];
      end
      $display("alu test done");
   endtask

   task automatic complete_run();
      $display("comparisons %0d mismatches %0d", cmp_count, errors);
      if (errors == 0 && cmp_count > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   initial begin
      repeat (5) @(posedge core_clk);
      #1;
      core_u.power_on = 1'b1;
      core_u.go();
      repeat (13) @(posedge core_clk);
      #1 resetn = 1'b1;
      check({program_counter_low, alu_flags_and_page}, 16'h0018, "reset");
      check(counter_prescale_config, 8'hFF, "option reset");
      alu_run(24);
      {core_u.option_wr_data, core_u.option_wr_en} = {8'h00, 1'b1};
      core_u.go();
      check(counter_prescale_config, 8'hC0, "option forced");
      seed = lfsr(seed);
      wr(`CSO_ADDR_PC_LOW, seed[7:0]);
      check(program_counter_low, seed[7:0], "pc write");
      ce = 1'b0;
      wr(`CSO_ADDR_PC_LOW, ~seed[7:0]);
      ce = 1'b1;
      check(program_counter_low, seed[7:0], "frozen");
      core_u.pc_step = 1'b1;
      core_u.go();
      {core_u.file_addr, core_u.file_rd_en} = {`CSO_ADDR_PC_LOW, 1'b1};
      core_u.go();
      check(file_rd_data, 8'(seed[7:0] + 8'h01), "pc step read");
      {core_u.file_addr, core_u.file_rd_en} = {5'h1F, 1'b1};
      core_u.go();
      check(file_rd_data, 8'h00, "unmapped read");
      for (int p = 0; p < 8; p++) begin
         wr(`CSO_ADDR_STATUS, {p[2:0], 5'h07});
         check({page_select, page_base, alu_flags_and_page},
               {p[2:0], p[2:0], 9'h000, p[2:0], st43, 3'h7}, "page");
      end
      fl = 3'h7;
      {core_u.alu_op, core_u.alu_opa, core_u.alu_opb, core_u.alu_valid} = {`CSO_OP_ADD, 16'h0101, 1'b1};
      e = alu_exp(`CSO_OP_ADD, 8'h01, 8'h01, fl, cf);
      wr(`CSO_ADDR_STATUS, 8'hE7);
      check(alu_flags_and_page, {3'h7, st43, e[8], e[9], e[10]}, "write then flags");
      fl = e[10:8];
      repeat (16) begin
         seed = lfsr(seed);
         {core_u.watchdog_timeout, core_u.sleep_instr, core_u.watchdog_kick_instr} = seed[2:0];
         st43 = {seed[2] ? 1'b0 : (|seed[2:0] | st43[1]), seed[1] ? 1'b0 : (seed[0] | st43[0])};
         core_u.go();
         check({watchdog_expired, sleep_entered_flag, alu_flags_and_page[4:3]}, {st43, st43}, "events");
      end
      {core_u.file_addr, core_u.file_rd_en} = {`CSO_ADDR_STATUS, 1'b1};
      core_u.go();
      check(file_rd_data, {3'h7, st43, fl[0], fl[1], fl[2]}, "status read");
      cfg(`CSO_CFG_EXT, 12'h000);
      check({config_word, extended_config_word}, 24'hFFFFFF, "locked");
      core_u.prog_mode = 1'b1;
      cfg(`CSO_CFG_EXT, 12'hF9F);
      check({config_word, extended_config_word}, 24'hFFFF9F, "config write");
      cfg(`CSO_CFG_DEVICE, 12'h000);
      core_u.go();
      check(cfg_rd_data, ID, "identity");
      core_u.prog_mode = 1'b0;
      core_u.go();
      check(cfg_rd_data, 12'h000, "config hidden");
      cf = 1'b0;
      seed = lfsr(seed);
      {core_u.option_wr_data, core_u.option_wr_en} = {seed[7:0], 1'b1};
      core_u.go();
      check(counter_prescale_config, seed[7:0], "option write");
      check({reg1_map_sel, rollover_irq_mask, count_clk_src, count_edge_sel, prescaler_assign, prescale_ratio},
            seed[7:0], "option decode");
      check({watchdog_ratio_onehot, counter_ratio_onehot}, 16'h0001 << seed[3:0], "ratio owner");
      alu_run(24);
      resetn = 1'b0;
      core_u.go();
      resetn = 1'b1;
      check(counter_prescale_config, 8'hFF, "option re-reset");
      $display("register test done");
      complete_run();
   end
endmodule // cpu_status_option_regs_bench

bind cso_regs cso_regs_chk chk_u (.*);
`default_nettype wire

/* File: verif/cso_core_model.sv */
// Purpose: Instruction core stand-in driving the register bank requests
// Assumes: Bench sets a request 1 ns after a rising edge, then calls go
// Notes:   Pulses drop after the taking edge; released operands are inverted
`timescale 1ns/100ps
`default_nettype none
module cso_core_model (
   input  wire logic        core_clk,
   output var  logic        power_on = 1'b0,
   output var  logic [4:0]  file_addr = 5'h00,
   output var  logic        file_wr_en = 1'b0,
   output var  logic        file_rd_en = 1'b0,
   output var  logic [7:0]  file_wr_data = 8'h00,
   output var  logic        pc_step = 1'b0,
   output var  logic        option_wr_en = 1'b0,
   output var  logic [7:0]  option_wr_data = 8'h00,
   output var  logic        alu_valid = 1'b0,
   output var  logic [2:0]  alu_op = 3'h0,
   output var  logic [7:0]  alu_opa = 8'h00,
   output var  logic [7:0]  alu_opb = 8'h00,
   output var  logic        watchdog_kick_instr = 1'b0,
   output var  logic        sleep_instr = 1'b0,
   output var  logic        watchdog_timeout = 1'b0,
   output var  logic        prog_mode = 1'b0,
   output var  logic        cfg_wr_en = 1'b0,
   output var  logic [1:0]  cfg_sel = 2'h0,
   output var  logic [11:0] cfg_wr_data = 12'h000
);
   // status writes only when a test asks; they never load the sleep and watchdog bits
   task automatic go();
      @(posedge core_clk);
      #1;
      {power_on, file_wr_en, file_rd_en, pc_step, option_wr_en, alu_valid, cfg_wr_en} = 7'h00;
      {watchdog_kick_instr, sleep_instr, watchdog_timeout} = 3'h0;
      file_wr_data = ~file_wr_data;
      alu_opa = ~alu_opa;
      alu_opb = ~alu_opb;
      // Idle edge keeps the next request out of this time step
      @(posedge core_clk);
      #1;
   endtask
endmodule // cso_core_model
`default_nettype wire

/* File: verif/cso_regs_chk.sv */
// Purpose: Concurrent checks on the status, program counter and option register bank
// Assumes: Bound to cso_regs; one clock domain
// Notes:   Flag sums are rebuilt from operands, never taken from the design
`timescale 1ns/100ps
`default_nettype none
`include "cso_defines.vh"
module cso_regs_chk (
   input wire logic        core_clk,
   input wire logic        resetn,
   input wire logic        ce,
   input wire logic        power_on,
   input wire logic [4:0]  file_addr,
   input wire logic        file_wr_en,
   input wire logic [7:0]  file_wr_data,
   input wire logic        option_wr_en,
   input wire logic [7:0]  option_wr_data,
   input wire logic        alu_valid,
   input wire logic [2:0]  alu_op,
   input wire logic [7:0]  alu_opa,
   input wire logic [7:0]  alu_opb,
   input wire logic [7:0]  alu_result,
   input wire logic        watchdog_kick_instr,
   input wire logic        sleep_instr,
   input wire logic        watchdog_timeout,
   input wire logic        prog_mode,
   input wire logic [7:0]  program_counter_low,
   input wire logic [7:0]  alu_flags_and_page,
   input wire logic [7:0]  counter_prescale_config,
   input wire logic [2:0]  page_select,
   input wire logic [11:0] page_base,
   input wire logic [11:0] config_word,
   input wire logic [11:0] extended_config_word
);
   wire logic       sub   = (alu_op == `CSO_OP_SUB);
   wire logic [7:0] b_eff = sub ? ~alu_opb : alu_opb;
   wire logic       c_in  = extended_config_word[5] ? sub : alu_flags_and_page[0];
   wire logic [8:0] sum9  = alu_opa + b_eff + c_in;
   wire logic [4:0] sum5  = alu_opa[3:0] + b_eff[3:0] + c_in;
   wire logic       rot_c = (alu_op == `CSO_OP_ROR) ? alu_opa[0] : alu_opa[7];
   wire logic       pd_nx = sleep_instr ? 1'b0 : (watchdog_kick_instr | alu_flags_and_page[3]);
   wire logic       ev    = watchdog_kick_instr | sleep_instr | watchdog_timeout;

   default clocking cb @(posedge core_clk); endclocking
   default disable iff (!resetn || !ce);

   a_opt_reset: assert property ($rose(resetn) |-> counter_prescale_config == 8'hFF &&
      alu_flags_and_page == 8'h18 && program_counter_low == 8'h00) else $error("reset values wrong");
   a_pc_write: assert property (file_wr_en && file_addr == `CSO_ADDR_PC_LOW |=>
      program_counter_low == $past(file_wr_data)) else $error("pc low write lost");
   a_ro_flags: assert property (file_wr_en && file_addr == `CSO_ADDR_STATUS && !ev && !power_on |=>
      $stable(alu_flags_and_page[4:3])) else $error("read-only flags written");
   a_page_map: assert property (page_select == alu_flags_and_page[7:5] && page_base == {page_select, 9'h000})
      else $error("page decode wrong");
   a_event_flags: assert property (ev && !power_on |=>
      alu_flags_and_page[4:3] == {!$past(watchdog_timeout), $past(pd_nx)}) else $error("event flags wrong");
   a_zero_flag: assert property (alu_valid && (alu_op == `CSO_OP_ADD || sub || alu_op == `CSO_OP_LOGIC) |=>
      alu_flags_and_page[2] == (alu_result == 8'h00)) else $error("zero flag wrong");
   a_arith_carry: assert property (alu_valid && (alu_op == `CSO_OP_ADD || sub) |=>
      {alu_flags_and_page[0], alu_result} == $past(sum9) && alu_flags_and_page[1] == $past(sum5[4]))
      else $error("carry flags wrong");
   a_rotate_carry: assert property (alu_valid && (alu_op == `CSO_OP_ROR || alu_op == `CSO_OP_ROL) |=>
      alu_flags_and_page[0] == $past(rot_c)) else $error("rotate carry wrong");
   a_option_map: assert property (option_wr_en |=> counter_prescale_config ==
      ($past(option_wr_data) | ($past(extended_config_word[6]) ? 8'hC0 : 8'h00))) else $error("option wrong");
   a_cfg_locked: assert property (!prog_mode && !power_on |=>
      $stable(config_word) && $stable(extended_config_word)) else $error("config word changed");

   c_status_alu: cover property (file_wr_en && file_addr == `CSO_ADDR_STATUS && alu_valid);
   c_timeout: cover property (watchdog_timeout && sleep_instr);
   c_sub_cin: cover property (alu_valid && sub && !extended_config_word[5]);
endmodule // cso_regs_chk
`default_nettype wire
